//--- design/ctoe_core.sv
// Execution core for the trap, transfer, test, wait and operand-fetch opcodes.
`timescale 1ns/1ns
`include "ctoe_consts.svh"
module ctoe_core #(
  parameter logic [15:0] TRAP_VECTOR = 16'hFF00
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [15:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  output logic             mem_rd,
  output logic             mem_wr,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        irq_req,
  output logic             cpu_clk_stop
);
  import ctoe_pkg::*;

  ctoe_if cif ();

  ctoe_regs u_regs (
    .clk      (clk),
    .rst_n    (rst_n),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .rif      (cif)
  );

  ctoe_ea u_ea (
    .eif (cif)
  );

  function automatic ctoe_mode_t fn_mode(input logic [7:0] op);
    ctoe_mode_t m;
    m = MD_INH;
    unique case (op[7:4])
      4'h0:                   m = MD_BTB;
      4'h1, 4'h3, 4'hB:       m = MD_DIR;
      4'h2, 4'hA:             m = MD_IMM;
      4'h4, 4'h5, 4'h8, 4'h9: m = MD_INH;
      4'h6, 4'hE:             m = MD_IX1;
      4'h7, 4'hF:             m = MD_IX;
      4'hC:                   m = MD_EXT;
      4'hD:                   m = MD_IX2;
    endcase
    return m;
  endfunction : fn_mode

  function automatic logic [1:0] fn_nbytes(input ctoe_mode_t m);
    logic [1:0] n;
    n = 2'd0;
    unique case (m)
      MD_INH, MD_IX:         n = 2'd0;
      MD_DIR, MD_IX1, MD_IMM: n = 2'd1;
      MD_EXT, MD_IX2, MD_BTB: n = 2'd2;
    endcase
    return n;
  endfunction : fn_nbytes

  function automatic ctoe_cls_t fn_class(input logic [7:0] op);
    ctoe_cls_t c;
    c = CL_OTHER;
    if (op == `CTOE_OP_TRAP) c = CL_TRAP;
    else if (op == `CTOE_OP_TAX) c = CL_TAX;
    else if (op == `CTOE_OP_TXA) c = CL_TXA;
    else if (op == `CTOE_OP_WAIT) c = CL_WAIT;
    else if (op == `CTOE_OP_TST_A) c = CL_TSTA;
    else if (op == `CTOE_OP_TST_X) c = CL_TSTX;
    else if (op == `CTOE_OP_TST_DIR || op == `CTOE_OP_TST_IX1 || op == `CTOE_OP_TST_IX)
      c = CL_TSTM;
    else if (op[7:4] == 4'h0) c = CL_BTB;
    return c;
  endfunction : fn_class

  function automatic logic [3:0] fn_ncyc(input logic [7:0] op);
    logic [3:0] n;
    n = `CTOE_CYC_OTHER_BASE;
    unique case (fn_class(op))
      CL_TRAP:         n = `CTOE_CYC_TRAP;
      CL_TAX, CL_TXA:  n = `CTOE_CYC_MOVE;
      CL_TSTA, CL_TSTX: n = `CTOE_CYC_TST_INH;
      CL_TSTM: n = (op == `CTOE_OP_TST_DIR) ? `CTOE_CYC_TST_DIR :
                   (op == `CTOE_OP_TST_IX1) ? `CTOE_CYC_TST_IX1 : `CTOE_CYC_TST_IX;
      CL_WAIT:         n = `CTOE_CYC_WAIT;
      CL_BTB:          n = `CTOE_CYC_BTB;
      CL_OTHER:        n = `CTOE_CYC_OTHER_BASE + {2'b00, fn_nbytes(fn_mode(op))};
    endcase
    return n;
  endfunction : fn_ncyc

  // Only N and Z move; H, I and C pass through untouched.
  function automatic ctoe_flags_t fn_tst(input ctoe_flags_t f, input logic [7:0] v);
    ctoe_flags_t r;
    r   = f;
    r.n = v[7];
    r.z = (v == 8'h00);
    return r;
  endfunction : fn_tst

  ctoe_state_t state_q, state_d;
  ctoe_cls_t   cls_q, op_cls;
  ctoe_mode_t  mode_q, op_mode;
  ctoe_flags_t flags_q, flags_d;
  logic [3:0]  cnt_q, cnt_d, ncyc_q, op_ncyc, nk;
  logic [1:0]  nb_q, op_nb;
  logic [7:0]  opcode_q, opcode_d, opr_q, opr_d, acc_q, acc_d, idx_q, idx_d;
  logic [15:0] pc_q, pc_d, sp_q, sp_d;
  logic [15:0] mem_addr_q, addr_d;
  logic [7:0]  mem_wdata_q, wdata_d;
  logic        mem_rd_q, rd_d, mem_wr_q, wr_d;
  logic        bit_val;

  assign cif.mode   = op_mode;
  assign cif.prev_b = opr_q;
  assign cif.last_b = mem_rdata;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    pc_d    = pc_q;
    acc_d   = acc_q;
    idx_d   = idx_q;
    sp_d    = sp_q;
    flags_d = flags_q;
    opr_d   = opr_q;
    opcode_d = opcode_q;
    op_cls  = cls_q;
    op_mode = mode_q;
    op_nb   = nb_q;
    op_ncyc = ncyc_q;
    rd_d    = 1'b0;
    wr_d    = 1'b0;
    addr_d  = mem_addr_q;
    wdata_d = mem_wdata_q;
    bit_val = mem_rdata[opcode_q[3:1]];
    nk      = cnt_q + 4'h1;
    unique case (state_q)
      ST_HALT: begin
        if (cif.pc_load) begin
          pc_d = cif.pc_load_val;
        end else if (cif.run) begin
          state_d = ST_RUN;
          cnt_d   = 4'h0;
          rd_d    = 1'b1;
          addr_d  = pc_q;
        end
      end
      ST_WAIT: begin
        // Wake simply resumes at the next opcode; no interrupt sequence is taken.
        if (irq_req) begin
          state_d = ST_RUN;
          cnt_d   = 4'h0;
          rd_d    = 1'b1;
          addr_d  = pc_q;
        end
      end
      ST_RUN: begin
        if (cnt_q == 4'h0) begin
          opcode_d = mem_rdata;
          op_cls   = fn_class(mem_rdata);
          op_mode  = fn_mode(mem_rdata);
          op_nb    = fn_nbytes(fn_mode(mem_rdata));
          op_ncyc  = fn_ncyc(mem_rdata);
          pc_d     = pc_q + 16'h0001;
        end else if (cnt_q <= {2'b00, nb_q}) begin
          opr_d = mem_rdata;
          pc_d  = pc_q + 16'h0001;
        end
        unique case (op_cls)
          CL_TAX:  if (cnt_q == 4'h1) idx_d = acc_q;
          CL_TXA:  if (cnt_q == 4'h1) acc_d = idx_q;
          CL_TSTA: if (cnt_q == 4'h1) flags_d = fn_tst(flags_q, acc_q);
          CL_TSTX: if (cnt_q == 4'h1) flags_d = fn_tst(flags_q, idx_q);
          CL_TSTM: begin
            if (cnt_q == {2'b00, nb_q} + 4'h1) flags_d = fn_tst(flags_q, mem_rdata);
          end
          CL_BTB: begin
            if (cnt_q == {2'b00, nb_q} + 4'h1) begin
              flags_d.c = bit_val;
              if (bit_val ^ opcode_q[0]) begin
                pc_d = pc_q + {{8{opr_q[7]}}, opr_q};
              end
            end
          end
          CL_TRAP: begin
            if (cnt_q >= 4'h1 && cnt_q <= `CTOE_TRAP_PUSHES) sp_d = sp_q - 16'h0001;
            if (cnt_q == `CTOE_TRAP_PUSHES) flags_d.i = 1'b1;
            if (cnt_q == `CTOE_TRAP_PUSHES + 4'h1) pc_d[15:8] = mem_rdata;
            if (cnt_q == `CTOE_TRAP_PUSHES + 4'h2) pc_d[7:0] = mem_rdata;
          end
          CL_WAIT, CL_OTHER: begin
          end
        endcase
        if (op_cls == CL_TRAP) begin
          // Push order low PC, high PC, index, accumulator, flags.
          unique case (nk)
            4'h1: begin wr_d = 1'b1; addr_d = sp_d; wdata_d = pc_d[7:0]; end
            4'h2: begin wr_d = 1'b1; addr_d = sp_d; wdata_d = pc_q[15:8]; end
            4'h3: begin wr_d = 1'b1; addr_d = sp_d; wdata_d = idx_q; end
            4'h4: begin wr_d = 1'b1; addr_d = sp_d; wdata_d = acc_q; end
            4'h5: begin wr_d = 1'b1; addr_d = sp_d; wdata_d = {`CTOE_FLAGS_PAD, flags_q}; end
            4'h6: begin rd_d = 1'b1; addr_d = TRAP_VECTOR; end
            4'h7: begin rd_d = 1'b1; addr_d = TRAP_VECTOR + 16'h0001; end
            default: begin end
          endcase
        end else if (nk <= {2'b00, op_nb}) begin
          rd_d   = 1'b1;
          addr_d = pc_d;
        end else if (nk == {2'b00, op_nb} + 4'h1 && op_mode != MD_INH && op_mode != MD_IMM) begin
          rd_d   = 1'b1;
          addr_d = cif.ea;
        end
        if (nk == op_ncyc) begin
          cnt_d = 4'h0;
          rd_d  = cif.run;
          wr_d  = 1'b0;
          addr_d = pc_d;
          if (!cif.run) state_d = ST_HALT;
        end else begin
          cnt_d = nk;
        end
        if (op_cls == CL_WAIT && cnt_q == 4'h1) begin
          flags_d.i = 1'b0;
          state_d   = ST_WAIT;
          cnt_d     = 4'h0;
          rd_d      = 1'b0;
        end
      end
      default: state_d = ST_HALT;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q  <= ST_HALT;
      cnt_q    <= 4'h0;
      cls_q    <= CL_OTHER;
      mode_q   <= MD_INH;
      nb_q     <= 2'd0;
      ncyc_q   <= `CTOE_CYC_OTHER_BASE;
      opcode_q <= 8'h00;
      opr_q    <= 8'h00;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      cls_q    <= op_cls;
      mode_q   <= op_mode;
      nb_q     <= op_nb;
      ncyc_q   <= op_ncyc;
      opcode_q <= opcode_d;
      opr_q    <= opr_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc_q    <= `CTOE_RST_PC;
      acc_q   <= `CTOE_RST_ACC;
      idx_q   <= `CTOE_RST_IDX;
      sp_q    <= `CTOE_RST_SP;
      flags_q <= `CTOE_RST_FLAGS;
    end else begin
      pc_q    <= pc_d;
      acc_q   <= acc_d;
      idx_q   <= idx_d;
      sp_q    <= sp_d;
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_addr_q  <= 16'h0000;
      mem_wdata_q <= 8'h00;
      mem_rd_q    <= 1'b0;
      mem_wr_q    <= 1'b0;
    end else begin
      mem_addr_q  <= addr_d;
      mem_wdata_q <= wdata_d;
      mem_rd_q    <= rd_d;
      mem_wr_q    <= wr_d;
    end
  end

  assign mem_addr     = mem_addr_q;
  assign mem_wdata    = mem_wdata_q;
  assign mem_rd       = mem_rd_q;
  assign mem_wr       = mem_wr_q;
  assign cpu_clk_stop = (state_q == ST_WAIT);
  assign cif.pc       = pc_q;
  assign cif.acc      = acc_q;
  assign cif.idx      = idx_q;
  assign cif.sp       = sp_q;
  assign cif.flags    = flags_q;
  assign cif.waiting  = (state_q == ST_WAIT);
  assign cif.halted   = (state_q == ST_HALT);

  logic fetch_now, in_trap;
  assign fetch_now = (state_q == ST_RUN) && (cnt_q == 4'h0);
  assign in_trap   = (state_q == ST_RUN) && (cls_q == CL_TRAP);

  property p_trap_len;
    @(posedge clk) disable iff (!rst_n)
    (fetch_now && mem_rdata == `CTOE_OP_TRAP) |-> ##10 (fetch_now || state_q == ST_HALT);
  endproperty
  a_trap_len: assert property (p_trap_len) else $error("trap length wrong");

  property p_trap_push;
    @(posedge clk) disable iff (!rst_n)
    (in_trap && cnt_q == 4'h1) |-> (mem_wr_q && mem_addr_q == sp_q && mem_wdata_q == pc_q[7:0])
      ##1 (mem_wr_q && mem_wdata_q == pc_q[15:8]) ##1 (mem_wdata_q == idx_q)
      ##1 (mem_wdata_q == acc_q) ##1 (mem_wdata_q == {`CTOE_FLAGS_PAD, flags_q});
  endproperty
  a_trap_push: assert property (p_trap_push) else $error("trap push order wrong");

  property p_trap_sp;
    @(posedge clk) disable iff (!rst_n)
    (in_trap && cnt_q == 4'h1) |-> ##5 (sp_q == $past(sp_q, 5) - 16'h0005);
  endproperty
  a_trap_sp: assert property (p_trap_sp) else $error("trap stack pointer wrong");

  property p_trap_vec;
    @(posedge clk) disable iff (!rst_n)
    (in_trap && cnt_q == 4'h5) |=> (flags_q.i && mem_rd_q && mem_addr_q == TRAP_VECTOR)
      ##2 (pc_q == {$past(mem_rdata, 2), $past(mem_rdata, 1)});
  endproperty
  a_trap_vec: assert property (p_trap_vec) else $error("trap vector load wrong");

  property p_move;
    @(posedge clk) disable iff (!rst_n)
    (fetch_now && mem_rdata == `CTOE_OP_TAX) |-> ##2
      (idx_q == acc_q && flags_q == $past(flags_q, 2) && (fetch_now || state_q == ST_HALT));
  endproperty
  a_move: assert property (p_move) else $error("transfer wrong");

  property p_tst_dir;
    @(posedge clk) disable iff (!rst_n)
    (fetch_now && mem_rdata == `CTOE_OP_TST_DIR) |-> ##4 (fetch_now || state_q == ST_HALT);
  endproperty
  a_tst_dir: assert property (p_tst_dir) else $error("test length wrong");

  property p_tst_flags;
    @(posedge clk) disable iff (!rst_n)
    (fetch_now && mem_rdata == `CTOE_OP_TST_A) |-> ##2 (flags_q.n == acc_q[7]
      && flags_q.z == (acc_q == 8'h00) && flags_q.h == $past(flags_q.h, 2)
      && flags_q.i == $past(flags_q.i, 2) && flags_q.c == $past(flags_q.c, 2));
  endproperty
  a_tst_flags: assert property (p_tst_flags) else $error("test flags wrong");

  property p_wait;
    @(posedge clk) disable iff (!rst_n)
    (fetch_now && mem_rdata == `CTOE_OP_WAIT) |-> ##2 (state_q == ST_WAIT && !flags_q.i);
  endproperty
  a_wait: assert property (p_wait) else $error("wait entry wrong");

  property p_wait_idle;
    @(posedge clk) disable iff (!rst_n)
    (state_q == ST_WAIT) |-> (!mem_rd_q && !mem_wr_q && cpu_clk_stop);
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("bus active in wait");

  property p_ix2;
    @(posedge clk) disable iff (!rst_n)
    (fetch_now && mem_rdata[7:4] == 4'hD) |-> ##3
      (mem_rd_q && mem_addr_q == {8'h00, idx_q} + {$past(mem_rdata, 2), $past(mem_rdata, 1)});
  endproperty
  a_ix2: assert property (p_ix2) else $error("word offset address wrong");

  property p_ext;
    @(posedge clk) disable iff (!rst_n)
    (fetch_now && mem_rdata[7:4] == 4'hC) |-> ##3
      (mem_rd_q && mem_addr_q == {$past(mem_rdata, 2), $past(mem_rdata, 1)});
  endproperty
  a_ext: assert property (p_ext) else $error("extended address wrong");

  property p_btb;
    @(posedge clk) disable iff (!rst_n)
    (fetch_now && mem_rdata[7:4] == 4'h0) |-> ##3
      (mem_rd_q && mem_addr_q == {8'h00, $past(mem_rdata, 2)});
  endproperty
  a_btb: assert property (p_btb) else $error("bit branch address wrong");
endmodule : ctoe_core

//--- common/ctoe_consts.svh
// Opcodes, cycle counts, register offsets and reset values of the tail opcode core.
`ifndef CTOE_CONSTS_SVH
`define CTOE_CONSTS_SVH

`define CTOE_OP_TRAP        8'h83
`define CTOE_OP_TAX         8'h97
`define CTOE_OP_TXA         8'h9F
`define CTOE_OP_WAIT        8'h8F
`define CTOE_OP_TST_DIR     8'h3D
`define CTOE_OP_TST_A       8'h4D
`define CTOE_OP_TST_X       8'h5D
`define CTOE_OP_TST_IX1     8'h6D
`define CTOE_OP_TST_IX      8'h7D

`define CTOE_CYC_TRAP       4'hA
`define CTOE_CYC_MOVE       4'h2
`define CTOE_CYC_TST_DIR    4'h4
`define CTOE_CYC_TST_INH    4'h3
`define CTOE_CYC_TST_IX1    4'h5
`define CTOE_CYC_TST_IX     4'h4
`define CTOE_CYC_WAIT       4'h2
`define CTOE_CYC_BTB        4'h5
`define CTOE_CYC_OTHER_BASE 4'h2
`define CTOE_TRAP_PUSHES    4'h5

`define CTOE_REG_CTRL       8'h00
`define CTOE_REG_PC         8'h04
`define CTOE_REG_ACC        8'h08
`define CTOE_REG_IDX        8'h0C
`define CTOE_REG_SP         8'h10
`define CTOE_REG_FLAGS      8'h14
`define CTOE_REG_STAT       8'h18

`define CTOE_RST_PC         16'h0000
`define CTOE_RST_SP         16'h00FF
`define CTOE_RST_ACC        8'h00
`define CTOE_RST_IDX        8'h00
`define CTOE_RST_FLAGS      5'h08
`define CTOE_FLAGS_PAD      3'h7
`define CTOE_ZP_HI          8'h00

`endif

//--- common/ctoe_pkg.sv
// Types shared by the tail opcode core and its helpers.
package ctoe_pkg;
  typedef enum logic [1:0] {
    ST_HALT = 2'b00,
    ST_RUN  = 2'b01,
    ST_WAIT = 2'b10
  } ctoe_state_t;

  typedef enum logic [2:0] {
    MD_INH = 3'b000,
    MD_DIR = 3'b001,
    MD_EXT = 3'b010,
    MD_IX2 = 3'b011,
    MD_IX1 = 3'b100,
    MD_IX  = 3'b101,
    MD_BTB = 3'b110,
    MD_IMM = 3'b111
  } ctoe_mode_t;

  typedef enum logic [3:0] {
    CL_OTHER = 4'b0000,
    CL_TRAP  = 4'b0001,
    CL_TAX   = 4'b0010,
    CL_TXA   = 4'b0011,
    CL_TSTA  = 4'b0100,
    CL_TSTX  = 4'b0101,
    CL_TSTM  = 4'b0110,
    CL_WAIT  = 4'b0111,
    CL_BTB   = 4'b1000
  } ctoe_cls_t;

  typedef struct packed {
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } ctoe_flags_t;
endpackage : ctoe_pkg

//--- common/ctoe_if.sv
// Signals between the core, its register file and its address unit.
`timescale 1ns/1ns
interface ctoe_if;
  import ctoe_pkg::*;
  logic        run;
  logic        pc_load;
  logic [15:0] pc_load_val;
  logic [15:0] pc;
  logic [7:0]  acc;
  logic [7:0]  idx;
  logic [15:0] sp;
  ctoe_flags_t flags;
  logic        waiting;
  logic        halted;
  ctoe_mode_t  mode;
  logic [7:0]  prev_b;
  logic [7:0]  last_b;
  logic [15:0] ea;

  modport regs (output run, pc_load, pc_load_val,
                input  pc, acc, idx, sp, flags, waiting, halted);
  modport ea_unit (input mode, idx, prev_b, last_b, output ea);
  modport core (input  run, pc_load, pc_load_val, ea,
                output pc, acc, idx, sp, flags, waiting, halted, mode, prev_b, last_b);
endinterface : ctoe_if

//--- design/ctoe_ea.sv
// Effective address calculation for the operand addressing forms.
`timescale 1ns/1ns
`include "ctoe_consts.svh"
module ctoe_ea (
  ctoe_if.ea_unit eif
);
  import ctoe_pkg::*;

  always_comb begin
    unique case (eif.mode)
      MD_DIR: eif.ea = {`CTOE_ZP_HI, eif.last_b};
      MD_EXT: eif.ea = {eif.prev_b, eif.last_b};
      MD_IX2: eif.ea = {`CTOE_ZP_HI, eif.idx} + {eif.prev_b, eif.last_b};
      MD_IX1: eif.ea = {`CTOE_ZP_HI, eif.idx} + {`CTOE_ZP_HI, eif.last_b};
      MD_IX:  eif.ea = {`CTOE_ZP_HI, eif.idx};
      MD_BTB: eif.ea = {`CTOE_ZP_HI, eif.prev_b};
      MD_INH: eif.ea = 16'h0000;
      MD_IMM: eif.ea = 16'h0000;
    endcase
  end
endmodule : ctoe_ea

//--- design/ctoe_regs.sv
// Classic Wishbone slave holding the control and status words of the core.
`timescale 1ns/1ns
`include "ctoe_consts.svh"
module ctoe_regs (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  ctoe_if.regs             rif
);
  import ctoe_pkg::*;

  logic        ack_q;
  logic [31:0] dat_q;
  logic [31:0] rdata_d;
  logic        run_q;
  logic        pc_load_q;
  logic [15:0] pc_val_q;
  logic [7:0]  word_adr;
  logic        req;
  logic        wr_now;

  assign req      = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where ack is seen high, matching the master.
  assign wr_now   = req & ack_q & wb_we_i;
  assign word_adr = {wb_adr_i[7:2], 2'b00};

  always_comb begin
    unique case (word_adr)
      `CTOE_REG_CTRL:  rdata_d = {31'h00000000, run_q};
      `CTOE_REG_PC:    rdata_d = {16'h0000, rif.pc};
      `CTOE_REG_ACC:   rdata_d = {24'h000000, rif.acc};
      `CTOE_REG_IDX:   rdata_d = {24'h000000, rif.idx};
      `CTOE_REG_SP:    rdata_d = {16'h0000, rif.sp};
      `CTOE_REG_FLAGS: rdata_d = {24'h000000, `CTOE_FLAGS_PAD, rif.flags};
      `CTOE_REG_STAT:  rdata_d = {30'h00000000, rif.halted, rif.waiting};
      default:         rdata_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) begin
        dat_q <= rdata_d;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run_q     <= 1'b0;
      pc_load_q <= 1'b0;
      pc_val_q  <= `CTOE_RST_PC;
    end else begin
      pc_load_q <= 1'b0;
      if (wr_now && word_adr == `CTOE_REG_CTRL && wb_sel_i[0]) begin
        run_q <= wb_dat_i[0];
      end
      if (wr_now && word_adr == `CTOE_REG_PC && (wb_sel_i[1] | wb_sel_i[0])) begin
        pc_load_q <= 1'b1;
        pc_val_q  <= {wb_sel_i[1] ? wb_dat_i[15:8] : rif.pc[15:8],
                      wb_sel_i[0] ? wb_dat_i[7:0] : rif.pc[7:0]};
      end
    end
  end

  assign wb_ack_o        = ack_q;
  assign wb_dat_o        = dat_q;
  assign rif.run         = run_q;
  assign rif.pc_load     = pc_load_q;
  assign rif.pc_load_val = pc_val_q;
endmodule : ctoe_regs

//--- verif/ctoe_core_tb.sv
// Self-checking bench for the tail opcode core, with a flat memory behind its bus.
`timescale 1ns/1ns
`include "ctoe_consts.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin num_errors++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); end end
module ctoe_core_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic        mem_rd;
  logic        mem_wr;
  logic [7:0]  mem_rdata;
  logic        irq_req = 1'b0;
  logic        cpu_clk_stop;
  logic [7:0]  mem [0:65535];
  int          fetch_t [int];
  int          cyc = 0;
  int          num_errors = 0;
  int          check_count = 0;
  logic [31:0] q;
  // Program at 0000: test dir, test A, bit branch, extended, word indexed, trap.
  localparam logic [119:0] PROG_LO = 120'h3D804D0080029D9DC61234D6010083;
  // Program at the vector target: move, test byte indexed, wait, move, wait,
  // test index, test no-offset indexed, wait, then a filler opcode to halt on.
  localparam logic [79:0]  PROG_HI = 80'h976D108F9F8F5D7D8F9D;

  ctoe_core DUT (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_rdata(mem_rdata), .irq_req(irq_req),
    .cpu_clk_stop(cpu_clk_stop));

  always #5 clk = ~clk;
  assign mem_rdata = mem[mem_addr];

  // Only the first read of each address is timed, so operand refetches do not blur counts.
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (mem_rd === 1'b1 && !fetch_t.exists(int'(mem_addr)))
      fetch_t[int'(mem_addr)] = cyc;
    if (mem_wr === 1'b1)
      mem[mem_addr] <= mem_wdata;
  end

  function automatic int ft(input int a);
    return fetch_t.exists(a) ? fetch_t[a] : -1000;
  endfunction : ft

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic wait_stop();
    int n;
    n = 0;
    while (cpu_clk_stop !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    `CHK(cpu_clk_stop, 1'b1)
  endtask : wait_stop

  task automatic t_idle_regs();
    wb(1'b0, `CTOE_REG_FLAGS, 32'h0);
    `CHK(q, 32'h000000E8)
    wb(1'b1, `CTOE_REG_ACC, 32'h000000FF);
    wb(1'b0, `CTOE_REG_ACC, 32'h0);
    `CHK(q, 32'h00000000)
    wb(1'b0, 8'h1C, 32'h0);
    `CHK(q, 32'h00000000)
  endtask : t_idle_regs

  task automatic t_run_to_wait();
    wb(1'b1, `CTOE_REG_CTRL, 32'h00000001);
    wait_stop();
    `CHK(ft(2) - ft(0), 4)
    `CHK(ft(3) - ft(2), 3)
    `CHK(ft(8) - ft(3), 5)
    `CHK(ft(6), -1000)
    `CHK(ft(16'h1234) - ft(8), 3)
    `CHK(ft(16'h0100) - ft(11), 3)
    `CHK(ft(16'h0200) - ft(14), 10)
    `CHK(ft(16'hFF01) - ft(16'hFF00), 1)
    `CHK(ft(16'h0201) - ft(16'h0200), 2)
    `CHK(ft(16'h0203) - ft(16'h0201), 5)
    `CHK({mem[16'h00FF], mem[16'h00FE], mem[16'h00FD]}, 24'h0F0000)
    `CHK({mem[16'h00FC], mem[16'h00FB]}, 16'h00EB)
    wb(1'b0, `CTOE_REG_SP, 32'h0);
    `CHK(q, 32'h000000FA)
    wb(1'b0, `CTOE_REG_FLAGS, 32'h0);
    `CHK(q, 32'h000000E3)
    wb(1'b0, `CTOE_REG_STAT, 32'h0);
    `CHK(q, 32'h00000001)
  endtask : t_run_to_wait

  task automatic t_wake();
    repeat (5) @(posedge clk);
    `CHK(ft(16'h0204), -1000)
    irq_req <= 1'b1;
    @(posedge clk);
    irq_req <= 1'b0;
    repeat (3) @(posedge clk);
    wait_stop();
    `CHK(ft(16'h0205) - ft(16'h0204), 2)
    wb(1'b0, `CTOE_REG_FLAGS, 32'h0);
    `CHK(q, 32'h000000E3)
    wb(1'b0, `CTOE_REG_PC, 32'h0);
    `CHK(q, 32'h00000206)
  endtask : t_wake

  // Index test sets Z from X (zero); the no-offset form then reads 3D at 0000 and clears Z.
  task automatic t_forms_halt();
    irq_req <= 1'b1;
    @(posedge clk);
    irq_req <= 1'b0;
    repeat (3) @(posedge clk);
    wait_stop();
    `CHK(ft(16'h0207) - ft(16'h0206), 3)
    `CHK(ft(16'h0208) - ft(16'h0207), 4)
    wb(1'b0, `CTOE_REG_FLAGS, 32'h0);
    `CHK(q, 32'h000000E1)
    wb(1'b1, `CTOE_REG_CTRL, 32'h00000000);
    irq_req <= 1'b1;
    @(posedge clk);
    irq_req <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK(ft(16'h020A), -1000)
    wb(1'b0, `CTOE_REG_STAT, 32'h0);
    `CHK(q, 32'h00000002)
    wb(1'b0, `CTOE_REG_PC, 32'h0);
    `CHK(q, 32'h0000020A)
    wb(1'b1, `CTOE_REG_PC, 32'h00000123);
    wb(1'b0, `CTOE_REG_PC, 32'h0);
    `CHK(q, 32'h00000123)
  endtask : t_forms_halt

  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
    for (int i = 0; i < 15; i++) mem[i] = PROG_LO[119 - 8 * i -: 8];
    for (int i = 0; i < 10; i++) mem[16'h0200 + i] = PROG_HI[79 - 8 * i -: 8];
    mem[16'h0080] = 8'h85;
    mem[16'hFF00] = 8'h02;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_idle_regs();
    t_run_to_wait();
    t_wake();
    t_forms_halt();
    test_done();
  end

  // The whole sequence needs well under two hundred cycles; this limit of 5000 cycles catches a hang.
  initial begin
    #50000;
    num_errors++;
    test_done();
  end
endmodule : ctoe_core_tb
